// ==== src/rslc_remote_status.sv ====
// remote status registers and serial link settings of the monitor
`include "rslc_regs.svh"
module rslc_remote_status
  import rslc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        cmd_valid,
  input  wire rslc_cmd_type cmd_code,
  input  wire logic        cmd_bit_mode,
  input  wire logic [2:0]  cmd_bit,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        lcmd_valid,
  input  wire rslc_lcmd_type lcmd_code,
  input  wire logic [18:0] lcmd_data,
  input  wire logic [7:0]  std_event_in,
  input  wire logic [7:0]  comm_error_in,
  input  wire logic [7:0]  overload_event_in,
  input  wire logic [7:0]  overload_cond_in,
  input  wire logic [7:0]  stb_aux_in,
  output logic      [7:0]  resp_data,
  output logic      [18:0] link_resp_data,
  output logic             resp_valid,
  output logic      [15:0] rate_divisor,
  output logic             rate_busy,
  output logic             bit_tick,
  output logic      [1:0]  flow_select,
  output logic      [2:0]  parity_select,
  output logic             pulse_status_mode,
  output logic             status_n
);
  //////////////////////////////////////////////////////////////////////////////
  logic [7:0]  std_event_reg;
  logic [7:0]  std_enable_reg;
  logic [7:0]  comm_error_event_reg;
  logic [7:0]  comm_error_enable_reg;
  logic [7:0]  overload_event_reg;
  logic [7:0]  overload_enable_reg;
  logic [7:0]  overload_condition_reg;
  logic [7:0]  cond_meta_reg;
  logic [7:0]  sre_reg;
  logic [7:0]  sre_next;
  logic [7:0]  stb_value;
  logic        std_sum;
  logic        ce_sum;
  logic        ov_sum;
  logic        service_req;
  logic        service_req_d_reg;
  logic        latch_reg;
  logic [7:0]  pulse_cnt_reg;
  logic [18:0] actual_rate;
  logic        cmd_go;
  logic        lcmd_go;

  assign cmd_go  = cmd_valid;
  assign lcmd_go = lcmd_valid && !cmd_valid;

  //////////////////////////////////////////////////////////////////////////////
  // condition inputs are asynchronous to mclk, so two flops first
  always_ff @(posedge mclk) begin
    if (reset) begin
      cond_meta_reg          <= 8'h00;
      overload_condition_reg <= 8'h00;
    end else begin
      cond_meta_reg          <= overload_cond_in;
      overload_condition_reg <= cond_meta_reg;
    end
  end

  rslc_event_reg u_std (
    .mclk          (mclk),
    .reset         (reset),
    .event_in      (std_event_in),
    .clear_all     (cmd_go && cmd_code == RSLC_CMD_CLS),
    .read_strobe   (cmd_go && cmd_code == RSLC_CMD_ESR_Q),
    .read_bit_mode (cmd_bit_mode),
    .read_bit      (cmd_bit),
    .en_write      (cmd_go && cmd_code == RSLC_CMD_ESE_W),
    .en_bit_mode   (cmd_bit_mode),
    .en_bit        (cmd_bit),
    .en_data       (cmd_data),
    .event_reg     (std_event_reg),
    .enable_reg    (std_enable_reg),
    .summary       (std_sum)
  );

  rslc_event_reg u_comm (
    .mclk          (mclk),
    .reset         (reset),
    .event_in      (comm_error_in),
    .clear_all     (cmd_go && cmd_code == RSLC_CMD_CLS),
    .read_strobe   (cmd_go && cmd_code == RSLC_CMD_COMM_ERROR_EVENT_REG_Q),
    .read_bit_mode (cmd_bit_mode),
    .read_bit      (cmd_bit),
    .en_write      (cmd_go && cmd_code == RSLC_CMD_COMM_ERROR_ENABLE_REG_W),
    .en_bit_mode   (cmd_bit_mode),
    .en_bit        (cmd_bit),
    .en_data       (cmd_data),
    .event_reg     (comm_error_event_reg),
    .enable_reg    (comm_error_enable_reg),
    .summary       (ce_sum)
  );

  rslc_event_reg u_ovl (
    .mclk          (mclk),
    .reset         (reset),
    .event_in      (overload_event_in),
    .clear_all     (cmd_go && cmd_code == RSLC_CMD_CLS),
    .read_strobe   (cmd_go && cmd_code == RSLC_CMD_OVERLOAD_EVENT_REG_Q),
    .read_bit_mode (cmd_bit_mode),
    .read_bit      (cmd_bit),
    .en_write      (cmd_go && cmd_code == RSLC_CMD_OVERLOAD_ENABLE_REG_W),
    .en_bit_mode   (cmd_bit_mode),
    .en_bit        (cmd_bit),
    .en_data       (cmd_data),
    .event_reg     (overload_event_reg),
    .enable_reg    (overload_enable_reg),
    .summary       (ov_sum)
  );

  //////////////////////////////////////////////////////////////////////////////
  // status byte summaries
  always_comb begin
    stb_value = stb_aux_in;
    stb_value[`RSLC_STB_ESB_BIT]  = std_sum;
    stb_value[`RSLC_STB_CESB_BIT] = ce_sum;
    stb_value[`RSLC_STB_OVSB_BIT] = ov_sum;
    stb_value[`RSLC_STB_MSS_BIT]  = 1'b0;
    stb_value[`RSLC_STB_MSS_BIT]  = |(stb_value & sre_reg);
  end
  assign service_req = stb_value[`RSLC_STB_MSS_BIT];

  always_comb begin
    sre_next = sre_reg;
    if (cmd_go && cmd_code == RSLC_CMD_SRE_W) begin
      if (cmd_bit_mode) begin
        sre_next[cmd_bit] = cmd_data[0];
      end else begin
        sre_next = cmd_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sre_reg <= 8'h00;
    end else begin
      sre_reg <= sre_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // response mux; reads see the value before the clearing edge
  function automatic logic [7:0] pick(input logic [7:0] v, input logic bm, input logic [2:0] b);
    pick = bm ? {7'h00, v[b]} : v;
  endfunction

  always_ff @(posedge mclk) begin
    if (reset) begin
      resp_data      <= 8'h00;
      link_resp_data <= 19'h00000;
      resp_valid     <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      if (cmd_go) begin
        resp_valid <= 1'b1;
        unique case (cmd_code)
          RSLC_CMD_STB_Q:  resp_data <= pick(stb_value, cmd_bit_mode, cmd_bit);
          RSLC_CMD_SRE_Q:  resp_data <= pick(sre_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_ESR_Q:  resp_data <= pick(std_event_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_ESE_Q:  resp_data <= pick(std_enable_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_COMM_ERROR_EVENT_REG_Q: resp_data <= pick(comm_error_event_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_COMM_ERROR_ENABLE_REG_Q: resp_data <= pick(comm_error_enable_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_OVERLOAD_CONDITION_REG_Q: resp_data <= pick(overload_condition_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_OVERLOAD_EVENT_REG_Q: resp_data <= pick(overload_event_reg, cmd_bit_mode, cmd_bit);
          RSLC_CMD_OVERLOAD_ENABLE_REG_Q: resp_data <= pick(overload_enable_reg, cmd_bit_mode, cmd_bit);
          default:         resp_valid <= 1'b0;
        endcase
      end else if (lcmd_go) begin
        resp_valid <= 1'b1;
        unique case (lcmd_code)
          RSLC_LCMD_RATE_Q: link_resp_data <= actual_rate;
          RSLC_LCMD_FLOW_Q: resp_data <= {6'h00, flow_select};
          RSLC_LCMD_PAR_Q:  resp_data <= {5'h00, parity_select};
          default: begin
            resp_valid <= 1'b0;
            if (lcmd_code == RSLC_LCMD_PULSE_STATUS_MODE_W) begin
              resp_valid <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // default divisor 32, which produces 9765
  rslc_rate_div u_rate (
    .mclk        (mclk),
    .reset       (reset),
    .set_rate    (lcmd_go && lcmd_code == RSLC_LCMD_RATE_W),
    .req_rate    (lcmd_data),
    .divisor     (rate_divisor),
    .actual_rate (actual_rate),
    .busy        (rate_busy),
    .bit_tick    (bit_tick)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      flow_select <= `RSLC_FLOW_DEFAULT;
    end else if (lcmd_go && lcmd_code == RSLC_LCMD_FLOW_W
                 && lcmd_data[1:0] <= `RSLC_FLOW_MAX && lcmd_data[18:2] == 17'h00000) begin
      flow_select <= lcmd_data[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      parity_select <= `RSLC_PARITY_DEFAULT;
    end else if (lcmd_go && lcmd_code == RSLC_LCMD_PAR_W
                 && lcmd_data[2:0] <= `RSLC_PARITY_MAX && lcmd_data[18:3] == 16'h0000) begin
      parity_select <= lcmd_data[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_status_mode <= 1'b0;
    end else if (lcmd_go && lcmd_code == RSLC_LCMD_PULSE_STATUS_MODE_W && lcmd_data[18:1] == 18'h00000) begin
      pulse_status_mode <= lcmd_data[0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk) begin
    if (reset) begin
      service_req_d_reg <= 1'b0;
    end else begin
      service_req_d_reg <= service_req;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      latch_reg <= 1'b0;
    end else if (!pulse_status_mode && service_req && !service_req_d_reg) begin
      latch_reg <= 1'b1;
    end else if (cmd_go && cmd_code == RSLC_CMD_STB_Q && !cmd_bit_mode) begin
      latch_reg <= 1'b0;
    end else if (pulse_status_mode) begin
      latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pulse_cnt_reg <= 8'h00;
    end else if (pulse_status_mode && service_req && !service_req_d_reg) begin
      pulse_cnt_reg <= `RSLC_PULSE_CYC;
    end else if (pulse_cnt_reg != 8'h00) begin
      pulse_cnt_reg <= pulse_cnt_reg - 8'h01;
    end
  end

  assign status_n = !(latch_reg || pulse_cnt_reg != 8'h00);

  a_stb_release: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == RSLC_CMD_STB_Q && !cmd_bit_mode && !(service_req && !service_req_d_reg)
     && pulse_cnt_reg == 8'h00) |=> status_n)
    else $error("status line not released by whole query");
  a_stb_bit_keep: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == RSLC_CMD_STB_Q && cmd_bit_mode && latch_reg) |=> !status_n)
    else $error("bit query released status line");
  a_pulse_width: assert property (@(posedge mclk) disable iff (reset)
    (pulse_status_mode && service_req && !service_req_d_reg) |=> (!status_n)[*8])
    else $error("status pulse too short");
  a_cls_zero: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == RSLC_CMD_CLS && std_event_in == 8'h00 && comm_error_in == 8'h00
     && overload_event_in == 8'h00) |=> (std_event_reg == 8'h00 && overload_event_reg == 8'h00
     && comm_error_event_reg == 8'h00))
    else $error("clear status left event bits");
  a_flow_legal: assert property (@(posedge mclk) disable iff (reset)
    flow_select <= `RSLC_FLOW_MAX)
    else $error("illegal flow code");
  a_parity_legal: assert property (@(posedge mclk) disable iff (reset)
    parity_select <= `RSLC_PARITY_MAX)
    else $error("illegal parity code");
  a_esr_clear: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == RSLC_CMD_ESR_Q && !cmd_bit_mode && std_event_in == 8'h00)
    |=> std_event_reg == 8'h00)
    else $error("standard event read did not clear");
  a_cond_stable: assert property (@(posedge mclk) disable iff (reset)
    (cmd_go && cmd_code == RSLC_CMD_OVERLOAD_CONDITION_REG_Q) |=> $stable(sre_reg))
    else $error("condition query altered state");

  c_pulse: cover property (@(posedge mclk) disable iff (reset)
    pulse_status_mode && service_req && !service_req_d_reg);
  c_latch_release: cover property (@(posedge mclk) disable iff (reset)
    latch_reg ##1 (cmd_go && cmd_code == RSLC_CMD_STB_Q && !cmd_bit_mode));
  c_rate_set: cover property (@(posedge mclk) disable iff (reset) $fell(rate_busy));
endmodule // rslc_remote_status

// ==== src/rslc_regs.svh ====
// register constants for the remote status and link configuration block
`ifndef RSLC_REGS_SVH
`define RSLC_REGS_SVH
`define RSLC_BASE_RATE       19'h4C4B4
`define RSLC_RATE_DEFAULT    19'h02580
`define RSLC_DIV_DEFAULT     16'h0020
`define RSLC_DIV_STEPS       5'h13
`define RSLC_FLOW_DEFAULT    2'h1
`define RSLC_FLOW_MAX        2'h2
`define RSLC_PARITY_DEFAULT  3'h0
`define RSLC_PARITY_MAX      3'h4
`define RSLC_CLK_MHZ         8'h28
`define RSLC_PULSE_US        8'h01
`define RSLC_PULSE_CYC       8'h28
`define RSLC_STB_ESB_BIT     3'h5
`define RSLC_STB_MSS_BIT     3'h6
`define RSLC_STB_CESB_BIT    3'h3
`define RSLC_STB_OVSB_BIT    3'h0
`endif

// ==== src/rslc_pkg.sv ====
// types for the remote status and link configuration block
package rslc_pkg;
  typedef enum logic [3:0] {
    RSLC_CMD_NONE, RSLC_CMD_CLS, RSLC_CMD_STB_Q, RSLC_CMD_SRE_W, RSLC_CMD_SRE_Q,
    RSLC_CMD_ESR_Q, RSLC_CMD_ESE_W, RSLC_CMD_ESE_Q, RSLC_CMD_COMM_ERROR_EVENT_REG_Q, RSLC_CMD_COMM_ERROR_ENABLE_REG_W,
    RSLC_CMD_COMM_ERROR_ENABLE_REG_Q, RSLC_CMD_OVERLOAD_CONDITION_REG_Q, RSLC_CMD_OVERLOAD_EVENT_REG_Q, RSLC_CMD_OVERLOAD_ENABLE_REG_W, RSLC_CMD_OVERLOAD_ENABLE_REG_Q
  } rslc_cmd_type;
  typedef enum logic [2:0] {
    RSLC_LCMD_NONE, RSLC_LCMD_RATE_W, RSLC_LCMD_RATE_Q, RSLC_LCMD_FLOW_W,
    RSLC_LCMD_FLOW_Q, RSLC_LCMD_PAR_W, RSLC_LCMD_PAR_Q, RSLC_LCMD_PULSE_STATUS_MODE_W
  } rslc_lcmd_type;
  typedef enum logic [1:0] {RSLC_DIV_IDLE, RSLC_DIV_RUN, RSLC_DIV_DONE} rslc_div_type;
endpackage

// ==== src/rslc_event_reg.sv ====
// one sticky event register with its enable mask
`include "rslc_regs.svh"
module rslc_event_reg
  import rslc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [7:0] event_in,
  input  wire logic       clear_all,
  input  wire logic       read_strobe,
  input  wire logic       read_bit_mode,
  input  wire logic [2:0] read_bit,
  input  wire logic       en_write,
  input  wire logic       en_bit_mode,
  input  wire logic [2:0] en_bit,
  input  wire logic [7:0] en_data,
  output logic      [7:0] event_reg,
  output logic      [7:0] enable_reg,
  output logic            summary
);
  logic [7:0] read_mask;
  logic [7:0] event_next;
  logic [7:0] enable_next;

  always_comb begin
    read_mask = 8'h00;
    if (read_strobe) begin
      read_mask = read_bit_mode ? (8'h01 << read_bit) : 8'hFF;
    end
    if (clear_all) begin
      read_mask = 8'hFF;
    end
    event_next = (event_reg & ~read_mask) | event_in;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      event_reg <= 8'h00;
    end else begin
      event_reg <= event_next;
    end
  end

  always_comb begin
    enable_next = enable_reg;
    if (en_write) begin
      if (en_bit_mode) begin
        enable_next[en_bit] = en_data[0];
      end else begin
        enable_next = en_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      enable_reg <= 8'h00;
    end else begin
      enable_reg <= enable_next;
    end
  end

  assign summary = |(event_reg & enable_reg);

  a_sticky_hold: assert property (@(posedge mclk) disable iff (reset)
    (event_reg != 8'h00 && !read_strobe && !clear_all) |=> ((event_reg & $past(event_reg)) == $past(event_reg)))
    else $error("event bit lost without read");
  a_bit_write_only: assert property (@(posedge mclk) disable iff (reset)
    (en_write && en_bit_mode) |=> ((enable_reg ^ $past(enable_reg)) & ~(8'h01 << $past(en_bit))) == 8'h00)
    else $error("indexed enable write touched other bits");
endmodule // rslc_event_reg

// ==== src/rslc_rate_div.sv ====
// serial rate divisor and bit enable generator
`include "rslc_regs.svh"
module rslc_rate_div
  import rslc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        set_rate,
  input  wire logic [18:0] req_rate,
  output logic      [15:0] divisor,
  output logic      [18:0] actual_rate,
  output logic             busy,
  output logic             bit_tick
);
  rslc_div_type state_reg;
  logic [18:0]  num_reg;
  logic [18:0]  part_reg;
  logic [18:0]  quot_reg;
  logic [18:0]  den_reg;
  logic [4:0]   step_reg;
  logic [15:0]  tick_cnt_reg;
  logic         act_phase_reg;
  logic [19:0]  trial;
  logic [19:0]  diff;
  logic         fits;
  logic [15:0]  new_div;

  assign busy = (state_reg != RSLC_DIV_IDLE);

  // one quotient bit per cycle keeps the busy window short
  always_comb begin
    trial   = {part_reg, num_reg[18]};
    diff    = trial - {1'b0, den_reg};
    fits    = (trial >= {1'b0, den_reg});
    new_div = quot_reg[15:0];
    if (quot_reg[18:16] != 3'h0) begin
      new_div = 16'hFFFF;
    end else if (quot_reg[15:0] == 16'h0000) begin
      new_div = 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg     <= RSLC_DIV_IDLE;
      num_reg       <= 19'h00000;
      part_reg      <= 19'h00000;
      quot_reg      <= 19'h00000;
      den_reg       <= 19'h00001;
      step_reg      <= 5'h00;
      act_phase_reg <= 1'b0;
      divisor       <= `RSLC_DIV_DEFAULT;
      actual_rate   <= 19'h00000;
    end else begin
      unique case (state_reg)
        RSLC_DIV_IDLE: begin
          if (set_rate && req_rate != 19'h00000) begin
            // base plus half the request rounds to nearest divisor
            num_reg       <= `RSLC_BASE_RATE + {1'b0, req_rate[18:1]};
            den_reg       <= req_rate;
            part_reg      <= 19'h00000;
            quot_reg      <= 19'h00000;
            step_reg      <= `RSLC_DIV_STEPS;
            act_phase_reg <= 1'b0;
            state_reg     <= RSLC_DIV_RUN;
          end else if (actual_rate == 19'h00000) begin
            num_reg       <= `RSLC_BASE_RATE;
            den_reg       <= {3'h0, `RSLC_DIV_DEFAULT};
            part_reg      <= 19'h00000;
            quot_reg      <= 19'h00000;
            step_reg      <= `RSLC_DIV_STEPS;
            act_phase_reg <= 1'b1;
            state_reg     <= RSLC_DIV_RUN;
          end
        end
        RSLC_DIV_RUN: begin
          if (step_reg != 5'h00) begin
            part_reg <= fits ? diff[18:0] : trial[18:0];
            num_reg  <= {num_reg[17:0], 1'b0};
            quot_reg <= {quot_reg[17:0], fits};
            step_reg <= step_reg - 5'h01;
          end else if (!act_phase_reg) begin
            divisor       <= new_div;
            num_reg       <= `RSLC_BASE_RATE;
            den_reg       <= {3'h0, new_div};
            part_reg      <= 19'h00000;
            quot_reg      <= 19'h00000;
            step_reg      <= `RSLC_DIV_STEPS;
            act_phase_reg <= 1'b1;
          end else begin
            state_reg <= RSLC_DIV_DONE;
          end
        end
        RSLC_DIV_DONE: begin
          actual_rate <= quot_reg;
          state_reg   <= RSLC_DIV_IDLE;
        end
        default: state_reg <= RSLC_DIV_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_cnt_reg <= 16'h0000;
      bit_tick     <= 1'b0;
    end else if (tick_cnt_reg + 16'h0001 >= divisor) begin
      tick_cnt_reg <= 16'h0000;
      bit_tick     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      bit_tick     <= 1'b0;
    end
  end
endmodule // rslc_rate_div

// ==== tb/rslc_host_model.sv ====
// host controller model: watches the status line and the link rate
module rslc_host_model
  import rslc_pkg::*;
#(
  parameter int HOST_RATE = 9600
)(
  input  wire logic        mclk,
  input  wire logic        status_n,
  input  wire logic [15:0] rate_divisor,
  output logic      [15:0] low_len,
  output logic             rate_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_len;
  int          dev_rate;
  always_comb begin
    dev_rate = (rate_divisor == 16'h0000) ? 0 : 312500 / rate_divisor;
    rate_ok  = (dev_rate - HOST_RATE) * 20 <= HOST_RATE && (HOST_RATE - dev_rate) * 20 <= HOST_RATE;
  end
  // measure each low stretch of the line
  initial begin
    run_len = 16'h0000;
    low_len = 16'h0000;
  end
  always @(posedge mclk) begin
    if (!status_n) begin
      run_len <= run_len + 16'h0001;
    end else if (run_len != 16'h0000) begin
      low_len <= run_len;
      run_len <= 16'h0000;
    end
  end
endmodule // rslc_host_model

// ==== tb/test_rslc_remote_status.sv ====
// testbench for the remote status and link settings block
module test_rslc_remote_status;
  import rslc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset = 1, cmd_valid = 0, cmd_bit_mode = 0, lcmd_valid = 0;
  rslc_cmd_type cmd_code = RSLC_CMD_NONE;
  rslc_lcmd_type lcmd_code = RSLC_LCMD_NONE;
  logic [2:0] cmd_bit = 3'h0;
  logic [7:0] cmd_data = 8'h00, ev_in [3], ovc = 8'h00, resp_data;
  logic [18:0] lcmd_data = 19'h00000, link_resp_data;
  logic resp_valid, rate_busy, bit_tick, pulse_status_mode, status_n, rate_ok;
  logic [15:0] rate_divisor, low_len;
  logic [1:0] flow_select;
  logic [2:0] parity_select;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  rslc_cmd_type qc [3] = '{RSLC_CMD_ESR_Q, RSLC_CMD_COMM_ERROR_EVENT_REG_Q, RSLC_CMD_OVERLOAD_EVENT_REG_Q};
  rslc_cmd_type ew [4] = '{RSLC_CMD_SRE_W, RSLC_CMD_ESE_W, RSLC_CMD_COMM_ERROR_ENABLE_REG_W, RSLC_CMD_OVERLOAD_ENABLE_REG_W};
  rslc_cmd_type eq [4] = '{RSLC_CMD_SRE_Q, RSLC_CMD_ESE_Q, RSLC_CMD_COMM_ERROR_ENABLE_REG_Q, RSLC_CMD_OVERLOAD_ENABLE_REG_Q};
  initial ev_in = '{8'h00, 8'h00, 8'h00};
  always #12.5 mclk = ~mclk;
  rslc_remote_status i_rslc_remote_status (.mclk(mclk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bit_mode(cmd_bit_mode), .cmd_bit(cmd_bit), .cmd_data(cmd_data),
    .lcmd_valid(lcmd_valid), .lcmd_code(lcmd_code), .lcmd_data(lcmd_data),
    .std_event_in(ev_in[0]), .comm_error_in(ev_in[1]), .overload_event_in(ev_in[2]),
    .overload_cond_in(ovc), .stb_aux_in(8'h00), .resp_data(resp_data),
    .link_resp_data(link_resp_data), .resp_valid(resp_valid), .rate_divisor(rate_divisor),
    .rate_busy(rate_busy), .bit_tick(bit_tick), .flow_select(flow_select),
    .parity_select(parity_select), .pulse_status_mode(pulse_status_mode), .status_n(status_n));
  rslc_host_model i_rslc_host_model (.mclk(mclk), .status_n(status_n),
    .rate_divisor(rate_divisor), .low_len(low_len), .rate_ok(rate_ok));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // status command; queries answer on the following cycle
  task automatic cmd(input rslc_cmd_type c, input logic bm, input logic [2:0] b,
                     input logic [7:0] d, input logic [8:0] exp = 9'h100);
    @(negedge mclk);
    cmd_valid = 1; cmd_code = c; cmd_bit_mode = bm; cmd_bit = b; cmd_data = d;
    @(negedge mclk);
    cmd_valid = 0; cmd_code = RSLC_CMD_NONE;
    if (!exp[8]) begin
      check(resp_valid, 1'b1);
      check(resp_data, exp[7:0]);
    end
  endtask
  task automatic lcmd(input rslc_lcmd_type c, input logic [18:0] d);
    @(negedge mclk);
    lcmd_valid = 1; lcmd_code = c; lcmd_data = d;
    @(negedge mclk);
    lcmd_valid = 0; lcmd_code = RSLC_LCMD_NONE;
  endtask
  task automatic wait_idle();
    @(negedge mclk);
    for (int n = 0; n < 40000 && rate_busy !== 1'b0; n++) @(negedge mclk);
  endtask
  task automatic ev(input int i, input logic [7:0] v);
    @(negedge mclk);
    ev_in[i] = v;
    @(negedge mclk);
    ev_in[i] = 8'h00;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge mclk);
    reset = 0;
    wait_idle();
    check(flow_select, 2'h1); // default flow
    check(parity_select, 3'h0); // default parity
    check(pulse_status_mode, 1'b0); // default latched
    check(rate_divisor, 16'h0020); // default divisor
    check(rate_ok, 1'b1); // host tolerance
    lcmd(RSLC_LCMD_RATE_Q, 19'h0);
    check(link_resp_data, 19'h02625); // produced rate
    lcmd(RSLC_LCMD_RATE_W, 19'h02580);
    wait_idle();
    check(rate_divisor, 16'h0021); // nearest divisor
    lcmd(RSLC_LCMD_RATE_W, 19'h0F424);
    lcmd(RSLC_LCMD_RATE_W, 19'h4C4B4);
    wait_idle();
    check(rate_divisor, 16'h0005); // busy write refused
    lcmd(RSLC_LCMD_RATE_Q, 19'h0);
    check(link_resp_data, 19'h0F424); // exact rate
    lcmd(RSLC_LCMD_RATE_W, 19'h4C4B4);
    wait_idle();
    check(rate_divisor, 16'h0001); // smallest divisor
    $display("test link rate done");
    for (int k = 0; k < 4; k++) begin
      lcmd(RSLC_LCMD_FLOW_W, 19'(k));
      check(flow_select, k < 3 ? 2'(k) : 2'h2); // flow codes
    end
    for (int k = 0; k < 6; k++) begin
      lcmd(RSLC_LCMD_PAR_W, 19'(k));
      check(parity_select, k < 5 ? 3'(k) : 3'h4); // parity codes
    end
    lcmd(RSLC_LCMD_PULSE_STATUS_MODE_W, 19'h1);
    lcmd(RSLC_LCMD_PULSE_STATUS_MODE_W, 19'h2);
    check(pulse_status_mode, 1'b1); // bad code ignored
    lcmd(RSLC_LCMD_PULSE_STATUS_MODE_W, 19'h0);
    check(pulse_status_mode, 1'b0); // off code
    $display("test link settings done");
    for (int i = 0; i < 4; i++) begin
      cmd(ew[i], 0, 3'h0, 8'hA5);
      cmd(eq[i], 0, 3'h0, 8'h00, 9'h0A5); // whole write
      cmd(ew[i], 1, 3'h1, 8'h01);
      cmd(eq[i], 0, 3'h0, 8'h00, 9'h0A7); // one bit only
      cmd(eq[i], 1, 3'h6, 8'h00, 9'h000); // bit read
      cmd(ew[i], 0, 3'h0, 8'h00);
    end
    $display("test enables done");
    for (int i = 0; i < 3; i++) begin
      ev(i, 8'h24);
      repeat (6) @(negedge mclk);
      cmd(qc[i], 1, 3'h2, 8'h00, 9'h001); // sticky bit
      cmd(qc[i], 0, 3'h0, 8'h00, 9'h020); // only read bit cleared
      cmd(qc[i], 0, 3'h0, 8'h00, 9'h000); // cleared
      ev(i, 8'h81);
    end
    cmd(RSLC_CMD_CLS, 0, 3'h0, 8'h00);
    for (int i = 0; i < 3; i++) cmd(qc[i], 0, 3'h0, 8'h00, 9'h000); // clear status
    ovc = 8'h81;
    repeat (4) @(negedge mclk);
    cmd(RSLC_CMD_OVERLOAD_CONDITION_REG_Q, 0, 3'h0, 8'h00, 9'h081); // condition read
    cmd(RSLC_CMD_OVERLOAD_CONDITION_REG_Q, 1, 3'h7, 8'h00, 9'h001); // bit read unchanged
    ovc = 8'h00;
    $display("test events done");
    cmd(RSLC_CMD_SRE_W, 0, 3'h0, 8'h20);
    cmd(RSLC_CMD_ESE_W, 0, 3'h0, 8'h01);
    ev(0, 8'h01);
    repeat (3) @(negedge mclk);
    check(status_n, 1'b0); // latched request
    cmd(RSLC_CMD_STB_Q, 1, 3'h5, 8'h00, 9'h001); // bit form
    check(status_n, 1'b0); // bit query keeps line
    cmd(RSLC_CMD_STB_Q, 0, 3'h0, 8'h00, 9'h060); // whole byte
    @(negedge mclk);
    check(status_n, 1'b1); // whole query releases
    cmd(RSLC_CMD_ESR_Q, 0, 3'h0, 8'h00, 9'h001);
    lcmd(RSLC_LCMD_PULSE_STATUS_MODE_W, 19'h1);
    ev(0, 8'h01);
    repeat (60) @(negedge mclk);
    check(status_n, 1'b1); // pulse ends by itself
    check(low_len, 16'h0028); // one microsecond pulse
    $display("test status line done");
    report_and_stop();
  end
endmodule // test_rslc_remote_status
